/* File: nbhost_pkg.sv */
`default_nettype none
package nbhost_pkg;
  localparam logic [3:0] START_READ = 4'hD;
  localparam logic [3:0] START_WRITE = 4'hE;
  localparam logic [3:0] SIZE_ONE_BYTE = 4'h0;
  localparam logic [3:0] ALL_ONES = 4'hF;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] ABORT_CODE = 4'hF;
  localparam int ADDR_NIBBLES = 7;
  localparam int ARRAY_SEL_BIT = 22;
  localparam logic [7:0] RESET_DATA = 8'h00;
  // wait for a sync before giving up, in clocks
  localparam logic [3:0] SYNC_WAIT_MAX = 4'h8;

  typedef struct packed {
    logic write;
    logic [3:0] dev_id;
    logic [27:0] addr;
    logic [7:0] data;
  } nbhost_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic ok;
  } nbhost_rsp_t;

  typedef struct packed {
    logic frame_n;
    logic [3:0] nib_o;
    logic nib_oe;
  } nbhost_pins_t;
endpackage
`default_nettype wire

/* File: nbhost_master.sv */
`timescale 1ns/100ps
`default_nettype none
module nbhost_master (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire nbhost_pkg::nbhost_req_t req,
  output logic req_ready,
  input wire logic abort_req,
  output logic rsp_valid,
  output var nbhost_pkg::nbhost_rsp_t rsp,
  output var nbhost_pkg::nbhost_pins_t pins,
  input wire logic [3:0] nibble_lines_in
);
  import nbhost_pkg::*;

  typedef enum logic [9:0] {
    S_IDLE = 10'b0000000001,
    S_START = 10'b0000000010,
    S_SEL = 10'b0000000100,
    S_ADDR = 10'b0000001000,
    S_SIZE = 10'b0000010000,
    S_WDATA = 10'b0000100000,
    S_TAR = 10'b0001000000,
    S_SYNC = 10'b0010000000,
    S_RDATA = 10'b0100000000,
    S_END = 10'b1000000000
  } nbhost_state_t;

  nbhost_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  nbhost_req_t cur, next_cur;
  nbhost_rsp_t next_rsp;
  logic next_rsp_valid;
  nbhost_pins_t next_pins;
  logic aborting, next_aborting;
  logic [3:0] sync_a, sync_b;

  // pick address nibble, most significant first
  function automatic logic [3:0] addr_nib(input logic [27:0] a, input logic [3:0] i);
    addr_nib = a[27 - 4 * i -: 4];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser for the returning nibble lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= 4'hF;
      sync_b <= 4'hF;
    end else begin
      sync_a <= nibble_lines_in;
      sync_b <= sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cur = cur;
    next_rsp = rsp;
    next_rsp_valid = 1'b0;
    next_aborting = 1'b0;
    next_pins = '{frame_n: 1'b1, nib_o: ALL_ONES, nib_oe: 1'b1};
    req_ready = (state == S_IDLE) && !abort_req;
    case (state)
      S_IDLE: begin
        if (abort_req) begin
          // frame low terminates, with abort nibble in the same clock; caller waits for write end
          next_pins = '{frame_n: 1'b0, nib_o: ABORT_CODE, nib_oe: 1'b1};
          next_aborting = 1'b1;
          next_state = S_END;
        end else if (req_valid) begin
          next_cur = req;
          // frame low with start code in the first field
          next_pins.frame_n = 1'b0;
          next_pins.nib_o = req.write ? START_WRITE : START_READ;
          next_state = S_START;
        end
      end
      S_START: begin
        next_pins.nib_o = cur.dev_id;
        next_state = S_SEL;
        next_cnt = 4'h0;
      end
      S_SEL, S_ADDR: begin
        next_pins.nib_o = addr_nib(cur.addr, cnt);
        next_cnt = cnt + 4'h1;
        next_state = (cnt == 4'(ADDR_NIBBLES - 1)) ? S_SIZE : S_ADDR;
      end
      S_SIZE: begin
        // one field per clock, fixed order; single byte only
        next_pins.nib_o = SIZE_ONE_BYTE;
        next_cnt = 4'h0;
        next_state = cur.write ? S_WDATA : S_TAR;
      end
      S_WDATA: begin
        if (cnt == 4'h0) begin
          next_pins.nib_o = cur.data[3:0];
          next_state = S_WDATA;
          next_cnt = 4'h1;
        end else begin
          next_pins.nib_o = cur.data[7:4];
          next_state = S_TAR;
          next_cnt = 4'h0;
        end
      end
      S_TAR: begin
        // drive ones one clock, then float for the target from the next state
        next_pins.nib_o = ALL_ONES;
        next_pins.nib_oe = 1'b1;
        next_cnt = 4'h0;
        next_state = S_SYNC;
      end
      S_SYNC: begin
        next_pins.nib_oe = 1'b0;
        next_cnt = cnt + 4'h1;
        // sampled two clocks late through the synchroniser
        if (cnt >= 4'h2 && sync_b == SYNC_READY) begin
          next_cnt = 4'h0;
          next_state = cur.write ? S_END : S_RDATA;
          next_rsp = '{data: RESET_DATA, ok: 1'b1};
          next_rsp_valid = cur.write;
        end else if (cnt == SYNC_WAIT_MAX) begin
          next_rsp = '{data: RESET_DATA, ok: 1'b0};
          next_rsp_valid = 1'b1;
          next_state = S_END;
        end
      end
      S_RDATA: begin
        next_pins.nib_oe = 1'b0;
        next_cnt = cnt + 4'h1;
        if (cnt == 4'h0) begin
          next_rsp.data[3:0] = sync_b;
        end else begin
          next_rsp.data[7:4] = sync_b;
          next_rsp_valid = 1'b1;
          next_state = S_END;
        end
      end
      S_END: begin
        // release unless aborting, let target drive its closing ones, then retake lines
        next_pins.nib_oe = aborting;
        next_pins.frame_n = 1'b1;
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      cur <= '0;
      rsp <= '0;
      rsp_valid <= 1'b0;
      aborting <= 1'b0;
      pins <= '{frame_n: 1'b1, nib_o: 4'hF, nib_oe: 1'b0};
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur <= next_cur;
      rsp <= next_rsp;
      rsp_valid <= next_rsp_valid;
      aborting <= next_aborting;
      pins <= next_pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_start_frame_low: assert property (@(posedge clk) disable iff (rst)
    (state == S_START) |-> (pins.frame_n == 1'b0 && pins.nib_oe))
    else $error("start field without frame low");
  a_size_one_byte: assert property (@(posedge clk) disable iff (rst)
    (state == S_SIZE) |=> (pins.nib_o == SIZE_ONE_BYTE))
    else $error("size field not one byte");
  a_turnaround_ones: assert property (@(posedge clk) disable iff (rst)
    (state == S_TAR) |=> (pins.nib_o == ALL_ONES && pins.nib_oe) ##1 !pins.nib_oe)
    else $error("turnaround not ones then float");
  a_addr_length: assert property (@(posedge clk) disable iff (rst)
    $rose(state == S_SEL) |-> ##7 (state == S_SIZE))
    else $error("address not seven nibbles");
  a_write_data_order: assert property (@(posedge clk) disable iff (rst)
    (state == S_WDATA && cnt == 4'h1) |-> (pins.nib_o == cur.data[3:0]))
    else $error("write low nibble wrong");
  a_float_for_target: assert property (@(posedge clk) disable iff (rst)
    ((state == S_SYNC && cnt != 4'h0) || state == S_RDATA) |-> !pins.nib_oe)
    else $error("host drives while target owns lines");
  a_frame_high_later: assert property (@(posedge clk) disable iff (rst)
    (state == S_SEL) |-> pins.frame_n)
    else $error("frame low beyond start field");
  a_abort_ones: assert property (@(posedge clk) disable iff (rst)
    (state == S_END && aborting) |-> (pins.nib_o == ABORT_CODE && !pins.frame_n))
    else $error("abort nibble missing");
endmodule // nbhost_master
`default_nettype wire

/* File: nbhost_target_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nbhost_target_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic frame_n,
  input wire logic [3:0] nibble_lines,
  input wire logic [3:0] identity_straps,
  output logic [3:0] nib_out,
  output logic nib_oe
);
  import nbhost_pkg::*;
  logic [4:0] cyc;
  logic [4:0] nxt;
  logic [3:0] start;
  logic [27:0] addr;
  logic [3:0] wlo;
  logic [7:0] mem [16];
  logic [7:0] rdat;
  logic rd;
  assign nxt = cyc + 5'h01;
  assign rd = (start == START_READ);
  ////////////////////////////////////////
  // field sequencer, fields sampled on the rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc <= 5'h00;
      start <= ALL_ONES;
      foreach (mem[i]) mem[i] <= 8'h00;
    end else if (!frame_n) begin
      cyc <= 5'h01;
      start <= nibble_lines;
    end else if (cyc != 5'h00) begin
      cyc <= (nxt == 5'h11) ? 5'h00 : nxt;
      if (nxt == 5'h02 && (nibble_lines != identity_straps ||
          !(start inside {START_READ, START_WRITE}))) cyc <= 5'h00;
      if (nxt inside {[5'h03:5'h09]}) addr <= {addr[23:0], nibble_lines};
      if (nxt == 5'h0A && nibble_lines != SIZE_ONE_BYTE) cyc <= 5'h00;
      if (!rd && nxt == 5'h0B) wlo <= nibble_lines;
      if (!rd && nxt == 5'h0C && addr[ARRAY_SEL_BIT])
        mem[addr[3:0]] <= {nibble_lines, wlo};
    end
  end
  ////////////////////////////////////////
  // drives only its own turnaround, sync and data cycles
  always_comb begin
    rdat = addr[ARRAY_SEL_BIT] ? mem[addr[3:0]] : RESET_DATA;
    nib_oe = rd ? (cyc inside {[5'h0B:5'h0F]}) : (cyc inside {[5'h0D:5'h0F]});
    nib_out = ALL_ONES;
    if (rd && cyc == 5'h0C) nib_out = SYNC_READY;
    if (rd && cyc == 5'h0D) nib_out = rdat[3:0];
    if (rd && cyc == 5'h0E) nib_out = rdat[7:4];
    if (!rd && cyc == 5'h0E) nib_out = SYNC_READY;
  end
endmodule // nbhost_target_model
`default_nettype wire

/* File: nbhost_master_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module nbhost_master_tb;
  import nbhost_pkg::*;
  localparam logic [3:0] MY_ID = 4'h5;
  logic clk, rst, req_valid, req_ready, abort_req, rsp_valid, dev_oe;
  nbhost_req_t req;
  nbhost_rsp_t rsp;
  nbhost_pins_t pins;
  logic [3:0] bus;
  logic [3:0] dev_out;
  int miscompares, comparisons, cycles;
  logic [7:0] shadow [int];
  // released lines float up to ones
  assign bus = pins.nib_oe ? pins.nib_o : (dev_oe ? dev_out : ALL_ONES);
  nbhost_master dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .abort_req(abort_req), .rsp_valid(rsp_valid), .rsp(rsp),
    .pins(pins), .nibble_lines_in(bus));
  nbhost_target_model target_u (.clk(clk), .rst(rst), .frame_n(pins.frame_n),
    .nibble_lines(bus), .identity_straps(MY_ID), .nib_out(dev_out), .nib_oe(dev_oe));
  ////////////////////////////////////////
  // compare and verdict
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] expect_rd(input logic [27:0] a);
    if (!a[ARRAY_SEL_BIT] || !shadow.exists(a[3:0])) return 8'h00;
    return shadow[a[3:0]];
  endfunction
  // one bus cycle through the request port, checked against the shadow
  task automatic xfer(input logic wr, input logic [3:0] id, input logic [27:0] a,
      input logic [7:0] d);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{write: wr, dev_id: id, addr: a, data: d};
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check({8'h00, rsp_valid}, 9'h001);
    if (id != MY_ID) check({8'h00, rsp.ok}, 9'h000);
    else if (wr) check(rsp, 9'h001);
    else check(rsp, {expect_rd(a), 1'b1});
    if (wr && id == MY_ID && a[ARRAY_SEL_BIT]) shadow[a[3:0]] = d;
  endtask
  ////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // host must be floating whenever the target drives
  always @(negedge clk) begin
    if (!rst && dev_oe) check({8'h00, pins.nib_oe}, 9'h000);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 6000) begin
      miscompares++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    logic [27:0] a;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    abort_req = 1'b0;
    void'($urandom(32'h3b2b));
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    xfer(1'b1, MY_ID, 28'h0400000, 8'hA5);
    xfer(1'b0, MY_ID, 28'h0400000, 8'h00);
    xfer(1'b1, MY_ID, 28'hFFFFFFF, 8'h3C);
    xfer(1'b0, MY_ID, 28'hFFFFFFF, 8'h00);
    xfer(1'b0, MY_ID, 28'h0000000, 8'h00);
    // abort from idle, only with no program running
    @(negedge clk);
    abort_req = 1'b1;
    for (int i = 0; i < 4 && pins.frame_n !== 1'b0; i++) @(negedge clk);
    check({4'h0, pins.frame_n, pins.nib_o}, {4'h0, 1'b0, ABORT_CODE});
    check({8'h00, req_ready}, 9'h000);
    @(negedge clk);
    abort_req = 1'b0;
    for (int k = 0; k < 30; k++) begin
      a = 28'($urandom());
      xfer(1'($urandom()), (k % 7 == 3) ? 4'h9 : MY_ID, a, 8'($urandom()));
    end
    print_verdict();
  end
endmodule // nbhost_master_tb
`default_nettype wire
